// File: pcrb_pkg.sv
package pcrb_pkg;

	// Instruction field positions
	localparam int OPC_LSB = 26;
	localparam int RS_LSB = 21;
	localparam int RT_LSB = 16;
	localparam int CC_LSB = 18;
	localparam int ND_BIT = 17;
	localparam int TF_BIT = 16;
	localparam int OFS_LSB = 0;

	// Encodings
	localparam logic [5:0] OP_EQUAL_BRANCH = 6'h04;
	localparam logic [5:0] OP_REGIMM = 6'h01;
	localparam logic [4:0] RT_NONNEG_LINK = 5'h11;
	localparam logic [5:0] OP_COP1 = 6'h11;
	localparam logic [4:0] FMT_BRANCH_COND = 5'h08;
	localparam logic [4:0] REG_ZERO = 5'h00;

	// Link and address steps
	localparam logic [4:0] LINK_REG = 5'h1F;
	localparam int SLOT_STEP = 4;
	localparam int LINK_STEP = 8;
	localparam int OFS_SHIFT = 2;
	localparam int TARGET_OFS_W = 18;

	// Values after reset
	localparam logic [63:0] RESET_ADDR = 64'h0;
	localparam logic [4:0] RESET_LINK_INDEX = 5'h00;

	typedef enum logic [1:0] {
		PCRB_EXC_NONE,
		PCRB_EXC_RESERVED,
		PCRB_EXC_CP_UNUSABLE,
		PCRB_EXC_FP_UNIMPL
	} pcrb_exc_type;

	typedef struct packed {
		logic is_branch;
		logic uncond;
		logic link;
		logic fp;
		logic nullify_slot_flag;
		logic truth_sense_flag;
		logic [2:0] fp_condition_select;
		logic [15:0] offset;
	} pcrb_decode_type;

endpackage : pcrb_pkg

// File: pcrb_decode.sv
`timescale 1ns/1ps
module pcrb_decode (
	input wire logic [31:0] instr,
	output pcrb_pkg::pcrb_decode_type dec
);
	logic [5:0] opc;
	logic [4:0] rs;
	logic [4:0] rt;
	logic eq_idiom;
	logic call_idiom;
	logic fp_br;

	always_comb begin
		opc = instr[pcrb_pkg::OPC_LSB +: 6];
		rs = instr[pcrb_pkg::RS_LSB +: 5];
		rt = instr[pcrb_pkg::RT_LSB +: 5];
		// Only the r0 forms: register compares belong to the integer branch unit
		eq_idiom = (opc == pcrb_pkg::OP_EQUAL_BRANCH) && (rs == pcrb_pkg::REG_ZERO)
			&& (rt == pcrb_pkg::REG_ZERO);
		call_idiom = (opc == pcrb_pkg::OP_REGIMM) && (rt == pcrb_pkg::RT_NONNEG_LINK)
			&& (rs == pcrb_pkg::REG_ZERO);
		fp_br = (opc == pcrb_pkg::OP_COP1) && (rs == pcrb_pkg::FMT_BRANCH_COND);
		dec.is_branch = eq_idiom | call_idiom | fp_br;
		dec.uncond = eq_idiom | call_idiom;
		dec.link = call_idiom;
		dec.fp = fp_br;
		dec.nullify_slot_flag = instr[pcrb_pkg::ND_BIT];
		dec.truth_sense_flag = instr[pcrb_pkg::TF_BIT];
		dec.fp_condition_select = instr[pcrb_pkg::CC_LSB +: 3];
		dec.offset = instr[pcrb_pkg::OFS_LSB +: 16];
	end
endmodule : pcrb_decode

// File: pcrb_branch_unit.sv
// What this block does
// - Branch-equal r0,r0 and nonneg-and-link on r0 are both always taken.
// - Target is delay-slot address plus sign-extended offset shifted left two.
// - Condition and target formed in branch cycle; redirect after the delay slot.
// - Call idiom writes branch address plus 8 into register 31.
// - Fault in delay slot restarts at the branch itself.
// - FP false branch taken only when selected condition bit is 0.
// - FP true branch taken only when selected condition bit is 1.
// - Likely branch not taken nullifies the delay-slot instruction.
// - FP branches are one operation steered by truth-sense and nullify flags.
// - Eight FP condition bits, chosen by the condition select field.
// - Condition bits are those written by the FP compare.
// - FP branches raise reserved, unusable or unimplemented faults; idioms raise none.
`timescale 1ns/1ps
module pcrb_branch_unit #(
	parameter int ADDR_W = 64,
	parameter int NUM_CC = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic issue_valid,
	input wire logic [31:0] issue_instr,
	input wire logic [ADDR_W-1:0] issue_pc,
	input wire logic slot_fault,
	input wire logic [NUM_CC-1:0] fp_cond_codes,
	input wire logic fpu_present,
	input wire logic fpu_usable,
	input wire logic fpu_unimpl,
	output logic redirect_valid,
	output logic [ADDR_W-1:0] redirect_pc,
	output logic link_we,
	output logic [4:0] link_index,
	output logic [ADDR_W-1:0] link_data,
	output logic slot_nullify,
	output logic exc_valid,
	output pcrb_pkg::pcrb_exc_type exc_cause,
	output logic restart_valid,
	output logic [ADDR_W-1:0] restart_pc,
	output logic slot_pending
);
	typedef enum logic {PCRB_IDLE, PCRB_SLOT} pcrb_state_type;

	pcrb_pkg::pcrb_decode_type dec;
	pcrb_state_type state_q, state_d;
	logic taken_q, taken_d;
	logic likely_q, likely_d;
	logic [ADDR_W-1:0] target_q, target_d;
	logic [ADDR_W-1:0] branch_pc_q, branch_pc_d;
	logic redirect_q, redirect_d;
	logic link_we_q, link_we_d;
	logic [4:0] link_index_q, link_index_d;
	logic [ADDR_W-1:0] link_data_q, link_data_d;
	logic nullify_q, nullify_d;
	logic exc_q, exc_d;
	pcrb_pkg::pcrb_exc_type cause_q, cause_d;
	logic restart_q, restart_d;
	logic [ADDR_W-1:0] restart_pc_q, restart_pc_d;
	logic pending_q, pending_d;
	logic [ADDR_W-1:0] ofs_ext;
	logic cc_bit;
	logic accept;

	pcrb_decode u_decode (
		.instr(issue_instr),
		.dec(dec)
	);

	always_comb begin
		ofs_ext = {{(ADDR_W-pcrb_pkg::TARGET_OFS_W){dec.offset[15]}}, dec.offset, 2'b00};
		cc_bit = fp_cond_codes[dec.fp_condition_select];
		accept = (state_q == PCRB_IDLE) && issue_valid && dec.is_branch;
		state_d = state_q;
		taken_d = taken_q;
		likely_d = likely_q;
		target_d = target_q;
		branch_pc_d = branch_pc_q;
		redirect_d = 1'b0;
		link_we_d = 1'b0;
		link_index_d = link_index_q;
		link_data_d = link_data_q;
		nullify_d = 1'b0;
		exc_d = 1'b0;
		cause_d = pcrb_pkg::PCRB_EXC_NONE;
		restart_d = 1'b0;
		restart_pc_d = restart_pc_q;
		case (state_q)
			PCRB_IDLE: begin
				if (accept) begin
					// Idioms never fault, so the checks are gated by dec.fp
					if (dec.fp && !fpu_present) begin
						exc_d = 1'b1;
						cause_d = pcrb_pkg::PCRB_EXC_RESERVED;
					end else if (dec.fp && !fpu_usable) begin
						exc_d = 1'b1;
						cause_d = pcrb_pkg::PCRB_EXC_CP_UNUSABLE;
					end else if (dec.fp && fpu_unimpl) begin
						exc_d = 1'b1;
						cause_d = pcrb_pkg::PCRB_EXC_FP_UNIMPL;
					end else begin
						// Both senses share one compare against the flag
						taken_d = dec.uncond | (cc_bit == dec.truth_sense_flag);
						likely_d = dec.fp & dec.nullify_slot_flag;
						target_d = issue_pc + ADDR_W'(pcrb_pkg::SLOT_STEP) + ofs_ext;
						branch_pc_d = issue_pc;
						state_d = PCRB_SLOT;
						if (dec.link) begin
							// Source is r0 by decode, so re-running the call is harmless
							link_we_d = 1'b1;
							link_index_d = pcrb_pkg::LINK_REG;
							link_data_d = issue_pc + ADDR_W'(pcrb_pkg::LINK_STEP);
						end
					end
				end
			end
			PCRB_SLOT: begin
				// Next instruction issued is the slot; a nested branch there is not checked
				if (issue_valid) begin
					state_d = PCRB_IDLE;
					if (slot_fault) begin
						restart_d = 1'b1;
						restart_pc_d = branch_pc_q;
					end else if (taken_q) begin
						redirect_d = 1'b1;
					end else if (likely_q) begin
						nullify_d = 1'b1;
					end
				end
			end
			default: begin
				state_d = PCRB_IDLE;
			end
		endcase
		// Registered copy of the slot wait so the pin comes from a flop
		pending_d = (state_d == PCRB_SLOT);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= PCRB_IDLE;
			taken_q <= 1'b0;
			likely_q <= 1'b0;
			target_q <= ADDR_W'(pcrb_pkg::RESET_ADDR);
			branch_pc_q <= ADDR_W'(pcrb_pkg::RESET_ADDR);
			redirect_q <= 1'b0;
			link_we_q <= 1'b0;
			link_index_q <= pcrb_pkg::RESET_LINK_INDEX;
			link_data_q <= ADDR_W'(pcrb_pkg::RESET_ADDR);
			nullify_q <= 1'b0;
			exc_q <= 1'b0;
			cause_q <= pcrb_pkg::PCRB_EXC_NONE;
			restart_q <= 1'b0;
			restart_pc_q <= ADDR_W'(pcrb_pkg::RESET_ADDR);
			pending_q <= 1'b0;
		end else begin
			state_q <= state_d;
			taken_q <= taken_d;
			likely_q <= likely_d;
			target_q <= target_d;
			branch_pc_q <= branch_pc_d;
			redirect_q <= redirect_d;
			link_we_q <= link_we_d;
			link_index_q <= link_index_d;
			link_data_q <= link_data_d;
			nullify_q <= nullify_d;
			exc_q <= exc_d;
			cause_q <= cause_d;
			restart_q <= restart_d;
			restart_pc_q <= restart_pc_d;
			pending_q <= pending_d;
		end
	end

	assign redirect_valid = redirect_q;
	assign redirect_pc = target_q;
	assign link_we = link_we_q;
	assign link_index = link_index_q;
	assign link_data = link_data_q;
	assign slot_nullify = nullify_q;
	assign exc_valid = exc_q;
	assign exc_cause = cause_q;
	assign restart_valid = restart_q;
	assign restart_pc = restart_pc_q;
	assign slot_pending = pending_q;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence branch_ok_s;
		accept && !exc_d;
	endsequence

	sequence slot_ok_s;
		(state_q == PCRB_SLOT) && issue_valid && !slot_fault;
	endsequence

	idiom_always_taken_a: assert property (branch_ok_s and dec.uncond |=> taken_q && !exc_q)
		else $error("unconditional idiom not taken");
	target_form_a: assert property (accept ##0 !exc_d |=>
		target_q == $past(issue_pc) + ADDR_W'(pcrb_pkg::SLOT_STEP)
		+ {{(ADDR_W-pcrb_pkg::TARGET_OFS_W){$past(issue_instr[15])}}, $past(issue_instr[15:0]), 2'b00})
		else $error("branch target wrong");
	redirect_after_slot_a: assert property (branch_ok_s ##1 (!issue_valid)[*1] |-> !redirect_q)
		else $error("redirect before delay slot");
	slot_redirect_a: assert property (slot_ok_s and taken_q |=> redirect_q && redirect_pc == $past(target_q))
		else $error("taken branch did not redirect after slot");
	link_value_a: assert property (branch_ok_s and dec.link |=>
		link_we_q && link_index_q == 5'h1F && link_data_q == $past(issue_pc) + ADDR_W'(8))
		else $error("link address wrong");
	slot_restart_a: assert property ((state_q == PCRB_SLOT) && issue_valid && slot_fault |=>
		restart_q && restart_pc_q == $past(branch_pc_q) && !redirect_q)
		else $error("slot fault restart wrong");
	fp_false_a: assert property (branch_ok_s and dec.fp && !dec.truth_sense_flag |=> taken_q == !$past(cc_bit))
		else $error("false branch sense wrong");
	fp_true_a: assert property (branch_ok_s and dec.fp && dec.truth_sense_flag |=> taken_q == $past(cc_bit))
		else $error("true branch sense wrong");
	likely_nullify_a: assert property (slot_ok_s and likely_q && !taken_q |=> nullify_q && !redirect_q)
		else $error("likely slot not nullified");
	cc_select_a: assert property (accept && dec.fp |->
		cc_bit == fp_cond_codes[issue_instr[pcrb_pkg::CC_LSB +: 3]])
		else $error("condition select wrong");
	fp_fault_a: assert property (accept && dec.fp && !fpu_usable |=> exc_q && state_q == PCRB_IDLE)
		else $error("unusable fault missing");
endmodule : pcrb_branch_unit

// File: pcrb_fpcc_model.sv
`timescale 1ns/1ps
module pcrb_fpcc_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic cmp_we,
	input wire logic [2:0] cmp_sel,
	input wire logic cmp_val,
	output logic [7:0] fp_cond_codes
);
	logic [7:0] cc_q;
	logic [7:0] cc_d;
	// Only the compare path writes the codes, so branches test compare results
	always_comb begin
		cc_d = cc_q;
		if (cmp_we) begin
			cc_d[cmp_sel] = cmp_val;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cc_q <= 8'h00;
		end else begin
			cc_q <= cc_d;
		end
	end
	assign fp_cond_codes = cc_q;
endmodule : pcrb_fpcc_model

// File: tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb;
	logic clk, reset, issue_valid, fault, present, usable, unimpl, cmp_we, cmp_val;
	logic [31:0] instr;
	logic [63:0] pc, rpc, ldata, rspc;
	logic [2:0] cmp_sel;
	logic [7:0] codes;
	logic [4:0] lidx;
	logic rv, lwe, nul, ev, rsv, pend;
	pcrb_pkg::pcrb_exc_type cause;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [7:0] pat = 8'hA5;
	logic [31:0] w;
	pcrb_fpcc_model fpcc (.clk(clk), .reset(reset), .cmp_we(cmp_we), .cmp_sel(cmp_sel), .cmp_val(cmp_val),
		.fp_cond_codes(codes));
	pcrb_branch_unit dut (.clk(clk), .reset(reset), .issue_valid(issue_valid), .issue_instr(instr), .issue_pc(pc),
		.slot_fault(fault), .fp_cond_codes(codes), .fpu_present(present), .fpu_usable(usable), .fpu_unimpl(unimpl),
		.redirect_valid(rv), .redirect_pc(rpc), .link_we(lwe), .link_index(lidx), .link_data(ldata),
		.slot_nullify(nul), .exc_valid(ev), .exc_cause(cause), .restart_valid(rsv), .restart_pc(rspc),
		.slot_pending(pend));
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	// Drive at the falling edge, look just after the rising edge that takes it
	task step(input logic v, input logic [31:0] iw, input logic [63:0] a, input logic f);
		@(negedge clk);
		issue_valid = v;
		instr = iw;
		pc = a;
		fault = f;
		@(posedge clk);
		#1;
	endtask : step
	task cmp_write(input logic [2:0] s, input logic v);
		@(negedge clk);
		cmp_we = 1'b1;
		cmp_sel = s;
		cmp_val = v;
		@(negedge clk);
		cmp_we = 1'b0;
	endtask : cmp_write
	// Branch then a nop slot at once; the next call issues right after the slot
	task br(input logic [31:0] iw, input logic [63:0] a, input logic f, input logic tk, input logic nl);
		step(1'b1, iw, a, 1'b0);
		`CHK("pending", 1'b1, pend)
		`CHK("early_redirect", 1'b0, rv)
		`CHK("exc", 1'b0, ev)
		`CHK("link_we", iw[31:26] == 6'h01, lwe)
		step(1'b1, 32'h00000000, a + 64'h4, f);
		`CHK("redirect", tk & !f, rv)
		`CHK("nullify", nl & !f, nul)
		`CHK("restart", f, rsv)
		if (f) `CHK("restart_pc", a, rspc)
		if (tk & !f) `CHK("target", a + 64'h4 + {{46{iw[15]}}, iw[15:0], 2'b00}, rpc)
	endtask : br
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		{reset, issue_valid, fault, cmp_we, cmp_val, unimpl} = 6'h20;
		{present, usable, instr, pc, cmp_sel} = '0;
		present = 1'b1;
		usable = 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		// Call idiom names register zero as source, never the link register
		br(32'h04110004, 64'h1000, 1'b0, 1'b1, 1'b0);
		`CHK("link_index", 5'h1F, lidx)
		`CHK("link_data", 64'h1008, ldata)
		br(32'h1000FFFC, 64'h2000, 1'b0, 1'b1, 1'b0);
		br(32'h10007FFF, 64'hFFFFFFFFFFFF0000, 1'b0, 1'b1, 1'b0);
		br(32'h04110008, 64'h3000, 1'b1, 1'b1, 1'b0);
		// Slot issued a cycle late: the redirect must wait for it
		step(1'b1, 32'h1000FFFC, 64'h7000, 1'b0);
		step(1'b0, 32'h00000000, 64'h0, 1'b0);
		`CHK("gap_pending", 1'b1, pend)
		`CHK("gap_redirect", 1'b0, rv)
		step(1'b1, 32'h00000000, 64'h7004, 1'b0);
		`CHK("gap_redirect", 1'b1, rv)
		`CHK("gap_target", 64'h6FF4, rpc)
		step(1'b1, 32'h10010004, 64'h3100, 1'b0);
		`CHK("not_branch", 1'b0, pend | lwe)
		for (int i = 0; i < 8; i++) begin
			cmp_write(i[2:0], pat[i]);
		end
		for (int k = 0; k < 32; k++) begin
			w = {6'h11, 5'h08, k[2:0], k[4], k[3], 16'h0010};
			br(w, 64'h4000, 1'b0, pat[k[2:0]] == k[3], k[4] & (pat[k[2:0]] != k[3]));
		end
		// Priority: missing unit, then unusable, then unimplemented
		for (int j = 0; j < 3; j++) begin
			@(negedge clk);
			issue_valid = 1'b0;
			present = (j != 0);
			usable = (j == 2);
			unimpl = 1'b1;
			step(1'b1, 32'h45000010, 64'h5000, 1'b0);
			`CHK("exc_valid", 1'b1, ev)
			`CHK("cause", pcrb_pkg::pcrb_exc_type'(j + 1), cause)
			`CHK("no_wait", 1'b0, pend | lwe)
		end
		// Idiom with every FP fault source active still raises nothing
		@(negedge clk);
		issue_valid = 1'b0;
		present = 1'b0;
		usable = 1'b0;
		br(32'h04110004, 64'h6000, 1'b0, 1'b1, 1'b0);
		step(1'b0, 32'h00000000, 64'h0, 1'b0);
		finish_test();
	end
endmodule : tb
